//--- design/spx_pkg.sv
// constants, field positions and types of the serial channel
// Function
// - sync mode moves 8-bit words, clock prescaled/2(n+1) or from clock pin
// - sync clock polarity bit picks rising or falling shift edge
// - bit order bit, sync mode only: 0 sends bit 0 first, 1 sends bit 7 first
// - multi-pin output routes the sync clock to exactly one of two pins
// - multi-pin output works only with the internal clock source
// - continuous receive, sync mode only: reading the receive buffer re-arms reception
// - async frame: start, 7/8/9 data, optional parity, one or two stops
// - internal async bit rate is prescaled clock over 16(n+1)
// - external async bit rate is clock pin rate over 16(n+1)
// - a channel without clock pin never uses an external clock
// - transmit starts only with transmit enabled and buffer holding data
// - async receive starts only when enabled and a start bit arrives
// - transmit request at buffer load or at shift end, by cause bit
// - receive request when a character enters the receive buffer
// - overrun flagged when new character arrives before buffer is read
// - on overrun buffer is overwritten and no receive request is made
// - framing error when configured stop bits are not found
// - parity error when ones count disagrees with odd or even setting
// - error sum flag is set by any overrun, framing or parity error
// - output idles high, or released when open drain, until transfer
// - clock pin is a plain port in async mode with internal clock, input when external
// - setting the sleep bit puts reception in multiprocessor sleep
// - in sleep only characters with data msb set are kept
`default_nettype none
package spx_pkg;
  localparam int AW = 8;
  localparam logic [AW-1:0] OFS_MODE = 8'h00;
  localparam logic [AW-1:0] OFS_CTL0 = 8'h04;
  localparam logic [AW-1:0] OFS_CTL1 = 8'h08;
  localparam logic [AW-1:0] OFS_CTL2 = 8'h0c;
  localparam logic [AW-1:0] OFS_BRG  = 8'h10;
  localparam logic [AW-1:0] OFS_TXB  = 8'h14;
  localparam logic [AW-1:0] OFS_RXB  = 8'h18;
  // field positions
  localparam int MD_EXT = 3, MD_STOP2 = 4, MD_PODD = 5;
  localparam int MD_PEN = 6, MD_SLEEP = 7;
  localparam int C0_OD = 5, C0_POL = 6, C0_MSB = 7;
  localparam int C1_TE = 0, C1_TBE = 1, C1_RE = 2, C1_RFULL = 3;
  localparam int C2_CAUSE = 0, C2_CONT = 2, C2_CKSEL = 4, C2_MULTI = 5;
  localparam int RB_OVR = 12, RB_FER = 13, RB_PER = 14, RB_SUM = 15;
  // mode field codes
  localparam logic [2:0] MODE_SYNC = 3'h1;
  localparam logic [2:0] MODE_A7 = 3'h4;
  localparam logic [2:0] MODE_A8 = 3'h5;
  localparam logic [2:0] MODE_A9 = 3'h6;
  localparam logic [7:0] RST_REG = 8'h00;
  // counts
  localparam logic [3:0] TK_MID = 4'h7;
  localparam logic [3:0] TK_LAST = 4'hf;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [4:0] PRE_DIV8 = 5'h07;
  localparam logic [4:0] PRE_DIV32 = 5'h1f;
  typedef enum logic [1:0] {T_IDLE, T_RUN} spx_tx_t;
  typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_DONE} spx_rx_t;
endpackage
`default_nettype wire

//--- design/spx_tick_if.sv
// bit rate generator hookup between channel and divider
`timescale 1ns/1ps
`default_nettype none
interface spx_tick_if;
  logic [1:0] src;      // prescale select
  logic [7:0] brg;      // divider value n
  logic       ext_sel;  // count clock pin edges
  logic       ext_edge; // clock pin rising edge
  logic       sub_edge; // sub oscillator rising edge
  logic       tick;     // one pulse per (n+1) source clocks
  modport gen (input src, brg, ext_sel, ext_edge, sub_edge, output tick);
  modport user (output src, brg, ext_sel, ext_edge, sub_edge, input tick);
endinterface
`default_nettype wire

//--- design/spx_sync.sv
// two-flop synchronisers with edge detect for pin inputs
`timescale 1ns/1ps
`default_nettype none
module spx_sync #(
  parameter int W = 3 // number of pins
) (
  input  wire logic         clk,  // system clock
  input  wire logic         rst,  // sync reset
  input  wire logic [W-1:0] d,    // raw pins
  output logic      [W-1:0] q,    // synchronised level
  output logic      [W-1:0] rise, // rising edge pulse
  output logic      [W-1:0] fall  // falling edge pulse
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      logic s1, s2, s3;
      // s1 only feeds s2, edges come from s2 and s3
      always_ff @(posedge clk) begin
        if (rst) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          s3 <= 1'b1;
        end else begin
          s1 <= d[g];
          s2 <= s1;
          s3 <= s2;
        end
      end
      assign q[g] = s2;
      assign rise[g] = s2 & ~s3;
      assign fall[g] = ~s2 & s3;
    end
  endgenerate
endmodule
`default_nettype wire

//--- design/spx_baud.sv
// prescaler and n+1 divider giving the 16x / half-period tick
`timescale 1ns/1ps
`default_nettype none
module spx_baud (
  input  wire logic clk, // system clock
  input  wire logic rst, // sync reset
  spx_tick_if.gen   t    // settings in, tick out
);
  import spx_pkg::*;
  logic [4:0] pre;
  logic [7:0] cnt;
  logic       pre_hit, src;
  // prescaled source clock pulse
  always_comb begin
    case (t.src)
      2'h0: pre_hit = 1'b1;
      2'h1: pre_hit = (pre[2:0] == PRE_DIV8[2:0]);
      2'h2: pre_hit = (pre == PRE_DIV32);
      default: pre_hit = t.sub_edge;
    endcase
    src = t.ext_sel ? t.ext_edge : pre_hit;
  end
  // free running prescaler
  always_ff @(posedge clk) begin
    if (rst) pre <= 5'h00;
    else pre <= pre + 5'h01;
  end
  // divide by n+1; 16 ticks per bit gives 16(n+1)
  always_ff @(posedge clk) begin
    t.tick <= 1'b0;
    if (rst) begin
      cnt <= 8'h00;
    end else if (src) begin
      if (cnt >= t.brg) begin
        cnt <= 8'h00;
        t.tick <= 1'b1;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- design/spx_serial_port.sv
// serial channel top: apb registers, sync and async engines, pins
`timescale 1ns/1ps
`default_nettype none
module spx_serial_port #(
  parameter bit HAS_CLK_PIN = 1'b1 // 0 for a channel with no clock pin
) (
  input  wire logic                  clk,          // 40 mhz clock
  input  wire logic                  rst,          // sync reset
  input  wire logic                  psel,         // apb select
  input  wire logic                  penable,      // apb enable
  input  wire logic                  pwrite,       // apb direction
  input  wire logic [spx_pkg::AW-1:0] paddr,       // apb byte address
  input  wire logic [31:0]           pwdata,       // apb write data
  output logic      [31:0]           prdata,       // apb read data
  output logic                       pready,       // apb ready
  output logic                       pslverr,      // unmapped address
  input  wire logic                  serial_in_pin,     // rx line
  output logic                       serial_out_pin,    // tx line level
  output logic                       serial_out_oe,     // tx line drive
  input  wire logic                  serial_clock_pin_in, // clock pin in
  output logic                       serial_clock_pin_out, // clock out
  output logic                       serial_clock_pin_oe,  // clock drive
  output logic                       alternate_clock_out_pin, // alt clk
  output logic                       alternate_clock_out_oe,  // alt drive
  input  wire logic                  sub_oscillator_clock, // slow source
  output logic                       tx_irq,       // transmit request
  output logic                       rx_irq        // receive request
);
  import spx_pkg::*;

  logic [7:0] mode, ctl0, brg;
  logic       te, re, cause, cont, cksel, multi;
  logic [8:0] txb, rxb, rx_val;
  logic       tx_full, rx_full, ovr, fer, per;
  logic       rx_done, rx_fe, rx_pe;
  logic [31:0] rdmux;
  logic        hit;
  spx_tx_t     tx_st;
  spx_rx_t     rs;
  logic [12:0] tx_sh;
  logic [11:0] rsh, al;
  logic [3:0]  tx_cnt, tk, rk, rcnt, clen, nbits;
  logic        ser_o, sclk_lv;
  logic [2:0]  pin_q, pin_rise, pin_fall;
  logic        rxq, ckq, is_sync, is_async, ext, idle_lv, int_clk, alt;
  logic        lead, trail, tx_go, sync_trail, acc, wr, rd_rxb;
  logic [8:0]  dmask;
  logic        stop_ok, msb_bit;

  spx_tick_if tif ();

  spx_sync #(.W(3)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .d    ({sub_oscillator_clock, serial_clock_pin_in, serial_in_pin}),
    .q    (pin_q),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  spx_baud u_baud (
    .clk (clk),
    .rst (rst),
    .t   (tif.gen)
  );

  // no clock pin means the external source is never chosen
  assign ext = mode[MD_EXT] & HAS_CLK_PIN;
  assign rxq = pin_q[0];
  assign ckq = pin_q[1];
  assign tif.src = ctl0[1:0];
  assign tif.brg = brg;
  assign tif.ext_sel = ext & ~is_sync;
  assign tif.ext_edge = pin_rise[1];
  assign tif.sub_edge = pin_rise[2];

  // mode decode and frame length
  always_comb begin
    is_sync = (mode[2:0] == MODE_SYNC);
    is_async = (mode[2:0] == MODE_A7) || (mode[2:0] == MODE_A8) ||
               (mode[2:0] == MODE_A9);
    if (mode[2:0] == MODE_A7) begin
      clen = 4'd7;
      dmask = 9'h07f;
    end else if (mode[2:0] == MODE_A9) begin
      clen = 4'd9;
      dmask = 9'h1ff;
    end else begin
      clen = 4'd8;
      dmask = 9'h0ff;
    end
    // bits after the start bit
    nbits = clen + {3'h0, mode[MD_PEN]} + 4'd1 +
            {3'h0, mode[MD_STOP2]};
  end

  // transfer clock edges: lead moves data out, trail samples
  always_comb begin
    idle_lv = ~ctl0[C0_POL];
    int_clk = is_sync & ~ext;
    alt = int_clk & multi & cksel;
    if (ext) begin
      lead = ctl0[C0_POL] ? pin_rise[1] : pin_fall[1];
      trail = ctl0[C0_POL] ? pin_fall[1] : pin_rise[1];
    end else begin
      lead = tif.tick & (sclk_lv == idle_lv);
      trail = tif.tick & (sclk_lv != idle_lv);
    end
    sync_trail = is_sync & (tx_st == T_RUN) & trail;
    // external clock must sit at idle level before a sync start
    tx_go = te & tx_full & (is_async |
            (is_sync & (~ext | (ckq == idle_lv))));
  end

  // reverse a byte when the msb-first order is chosen
  function automatic logic [7:0] ord8(input logic [7:0] d,
                                      input logic msb);
    logic [7:0] r;
    r = d;
    if (msb) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = d[7 - i];
      end
    end
    return r;
  endfunction

  // async frame, bit 0 first on the line, unused upper bits idle high
  function automatic logic [12:0] mk_frame(input logic [8:0] d,
                                           input logic [3:0] n,
                                           input logic pen,
                                           input logic odd);
    logic [12:0] f;
    logic        p;
    f = 13'h1fff;
    p = odd;
    f[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(n)) begin
        f[i + 1] = d[i];
        p = p ^ d[i];
      end
    end
    if (pen) f[n + 4'd1] = p;
    return f;
  endfunction

  // apb handshake: one wait state, read data latched in setup
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rd_rxb = acc & ~pwrite & (paddr == OFS_RXB);

  // read mux and address decode
  always_comb begin
    rdmux = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == OFS_MODE) begin
      rdmux[7:0] = mode;
    end else if (paddr == OFS_CTL0) begin
      rdmux[7:0] = ctl0;
    end else if (paddr == OFS_CTL1) begin
      rdmux[C1_TE] = te;
      rdmux[C1_TBE] = ~tx_full;
      rdmux[C1_RE] = re;
      rdmux[C1_RFULL] = rx_full;
    end else if (paddr == OFS_CTL2) begin
      rdmux[C2_CAUSE] = cause;
      rdmux[C2_CONT] = cont;
      rdmux[C2_CKSEL] = cksel;
      rdmux[C2_MULTI] = multi;
    end else if (paddr == OFS_BRG) begin
      rdmux[7:0] = brg;
    end else if (paddr == OFS_TXB) begin
      rdmux[8:0] = txb;
    end else if (paddr == OFS_RXB) begin
      rdmux[8:0] = rxb;
      rdmux[RB_OVR] = ovr;
      rdmux[RB_FER] = fer;
      rdmux[RB_PER] = per;
      rdmux[RB_SUM] = ovr | fer | per;
    end else begin
      hit = 1'b0;
    end
  end

  // apb answer flops
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      if (psel && !penable) prdata <= rdmux;
    end
  end

  // software written configuration
  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= RST_REG;
      ctl0 <= RST_REG;
      brg <= RST_REG;
      txb <= 9'h000;
      te <= 1'b0;
      re <= 1'b0;
      {cause, cont, cksel, multi} <= 4'h0;
    end else if (wr) begin
      if (paddr == OFS_MODE) begin
        mode <= pwdata[7:0];
      end else if (paddr == OFS_CTL0) begin
        ctl0 <= pwdata[7:0];
      end else if (paddr == OFS_CTL1) begin
        te <= pwdata[C1_TE];
        re <= pwdata[C1_RE];
      end else if (paddr == OFS_CTL2) begin
        cause <= pwdata[C2_CAUSE];
        cont <= pwdata[C2_CONT];
        cksel <= pwdata[C2_CKSEL];
        multi <= pwdata[C2_MULTI];
      end else if (paddr == OFS_BRG) begin
        brg <= pwdata[7:0];
      end else if (paddr == OFS_TXB) begin
        txb <= pwdata[8:0];
      end
    end
  end

  // transmit buffer full flag; a write in the load cycle is kept
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_full <= 1'b0;
    end else begin
      if (tx_st == T_IDLE && tx_go) tx_full <= 1'b0;
      // old dummy data is reused, so no rewrite is needed
      if (rd_rxb && cont && is_sync) tx_full <= 1'b1;
      if (wr && paddr == OFS_TXB) tx_full <= 1'b1;
    end
  end

  // transmit engine, shared by sync and async modes
  always_ff @(posedge clk) begin
    tx_irq <= 1'b0;
    if (rst) begin
      tx_st <= T_IDLE;
      ser_o <= 1'b1;
      sclk_lv <= 1'b1;
      tx_sh <= 13'h1fff;
      tx_cnt <= 4'h0;
      tk <= 4'h0;
    end else begin
      case (tx_st)
        T_IDLE: begin
          ser_o <= 1'b1;
          sclk_lv <= idle_lv;
          if (tx_go) begin
            tx_st <= T_RUN;
            tk <= 4'h0;
            tx_irq <= ~cause;
            if (is_sync) begin
              tx_sh <= {5'h1f, ord8(txb[7:0], ctl0[C0_MSB])};
              tx_cnt <= SYNC_BITS;
            end else begin
              ser_o <= 1'b0;
              // start bit goes out now, so the register keeps the rest
              tx_sh <= 13'({1'b1, mk_frame(txb, clen, mode[MD_PEN],
                                           mode[MD_PODD])} >> 1);
              tx_cnt <= nbits;
            end
          end
        end
        T_RUN: begin
          if (is_sync) begin
            if (int_clk && tif.tick) sclk_lv <= ~sclk_lv;
            if (lead) begin
              ser_o <= tx_sh[0];
              tx_sh <= {1'b1, tx_sh[12:1]};
            end
            if (trail) begin
              tx_cnt <= tx_cnt - 4'd1;
              if (tx_cnt == 4'd1) begin
                tx_st <= T_IDLE;
                tx_irq <= cause;
              end
            end
          end else if (tif.tick) begin
            tk <= tk + 4'd1;
            if (tk == TK_LAST) begin
              if (tx_cnt == 4'd0) begin
                tx_st <= T_IDLE;
                tx_irq <= cause;
              end else begin
                ser_o <= tx_sh[0];
                tx_sh <= {1'b1, tx_sh[12:1]};
                tx_cnt <= tx_cnt - 4'd1;
              end
            end
          end
        end
        default: tx_st <= T_IDLE;
      endcase
    end
  end

  // received frame aligned to bit 0, then checked
  always_comb begin
    al = rsh >> (4'd12 - nbits);
    stop_ok = al[clen + {3'h0, mode[MD_PEN]}] &
              (~mode[MD_STOP2] | al[clen + {3'h0, mode[MD_PEN]} + 4'd1]);
    msb_bit = al[clen - 4'd1];
  end

  // receive engine: sync shifts on trail edges, async oversamples
  always_ff @(posedge clk) begin
    rx_done <= 1'b0;
    if (rst) begin
      rs <= R_IDLE;
      rk <= 4'h0;
      rcnt <= 4'h0;
      rsh <= 12'h000;
      rx_val <= 9'h000;
      rx_fe <= 1'b0;
      rx_pe <= 1'b0;
    end else if (is_sync) begin
      rs <= R_IDLE;
      if (sync_trail && re) begin
        rsh <= {4'h0, rxq, rsh[7:1]};
        if (tx_cnt == 4'd1) begin
          rx_done <= 1'b1;
          rx_val <= {1'b0, ord8({rxq, rsh[7:1]}, ctl0[C0_MSB])};
          rx_fe <= 1'b0;
          rx_pe <= 1'b0;
        end
      end
    end else begin
      case (rs)
        R_IDLE: begin
          if (is_async && re && !rxq) begin
            rs <= R_START;
            rk <= 4'h0;
          end
        end
        R_START: begin
          if (tif.tick) begin
            rk <= rk + 4'd1;
            // a short low pulse is a glitch, not a start bit
            if (rk == TK_MID) begin
              rk <= 4'h0;
              rcnt <= nbits;
              rs <= rxq ? R_IDLE : R_DATA;
            end
          end
        end
        R_DATA: begin
          if (tif.tick) begin
            rk <= rk + 4'd1;
            if (rk == TK_LAST) begin
              rsh <= {rxq, rsh[11:1]};
              rcnt <= rcnt - 4'd1;
              if (rcnt == 4'd1) rs <= R_DONE;
            end
          end
        end
        R_DONE: begin
          rs <= R_IDLE;
          rx_val <= al[8:0] & dmask;
          rx_fe <= ~stop_ok;
          rx_pe <= mode[MD_PEN] &
                   (^(al[8:0] & dmask) ^ al[clen] ^ mode[MD_PODD]);
          // sleeping receiver drops characters with msb clear
          rx_done <= ~(mode[MD_SLEEP] & ~msb_bit);
        end
        default: rs <= R_IDLE;
      endcase
    end
  end

  // receive buffer and error flags; a new event beats a read clear
  always_ff @(posedge clk) begin
    rx_irq <= 1'b0;
    if (rst) begin
      rxb <= 9'h000;
      rx_full <= 1'b0;
      {ovr, fer, per} <= 3'h0;
    end else begin
      if (rd_rxb) begin
        rx_full <= 1'b0;
        {ovr, fer, per} <= 3'h0;
      end
      if (rx_done) begin
        rxb <= rx_val;
        if (rx_fe) fer <= 1'b1;
        if (rx_pe) per <= 1'b1;
        if (rx_full && !rd_rxb) begin
          ovr <= 1'b1;
        end else begin
          rx_full <= 1'b1;
          rx_irq <= 1'b1;
        end
      end
    end
  end

  // pin drivers; clock pin is left to the port when not clocking out
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_out_pin <= 1'b1;
      serial_out_oe <= 1'b1;
      serial_clock_pin_out <= 1'b1;
      serial_clock_pin_oe <= 1'b0;
      alternate_clock_out_pin <= 1'b1;
      alternate_clock_out_oe <= 1'b0;
    end else begin
      serial_out_pin <= ser_o;
      serial_out_oe <= ~(ctl0[C0_OD] & ser_o);
      serial_clock_pin_out <= sclk_lv;
      serial_clock_pin_oe <= int_clk & ~alt;
      alternate_clock_out_pin <= alt ? sclk_lv : idle_lv;
      alternate_clock_out_oe <= alt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_tx_start_cond: assert property ((tx_st == T_RUN) &&
    ($past(tx_st) == T_IDLE) |-> $past(te && tx_full))
    else $error("transmit started without enable or data");
  a_rx_start_cond: assert property ((rs == R_START) &&
    ($past(rs) == R_IDLE) |-> $past(re && !rxq && is_async))
    else $error("receive started without enable or start bit");
  a_overrun_flag: assert property (rx_done && rx_full &&
    !rd_rxb |=> ovr && !rx_irq && (rxb == $past(rx_val)))
    else $error("overrun not flagged or request raised");
  a_store_irq: assert property (rx_done && !rx_full |=>
    rx_irq && rx_full)
    else $error("stored character without receive request");
  a_async_idle: assert property (is_async &&
    (tx_st == T_IDLE) && $past(tx_st == T_IDLE) |-> ser_o)
    else $error("serial output not idle high");
  a_ext_no_clk: assert property (ext ##1 ext |->
    !serial_clock_pin_oe)
    else $error("clock pin driven with external clock");
  a_multi_int: assert property (alternate_clock_out_oe |->
    $past(!ext && multi && cksel && is_sync))
    else $error("alternate clock output without internal source");
  a_one_pin: assert property (!(alternate_clock_out_oe &&
    serial_clock_pin_oe))
    else $error("clock routed to both pins");
  a_sleep_drop: assert property ((rs == R_DONE) &&
    mode[MD_SLEEP] && !msb_bit && !is_sync |=> !rx_done)
    else $error("sleep mode kept a character with msb clear");
  a_tx_cause: assert property ((tx_st == T_RUN) &&
    ($past(tx_st) == T_IDLE) |-> (tx_irq == !$past(cause)))
    else $error("transmit request timing wrong");

  c_async_tx: cover property ((tx_st == T_RUN) && is_async ##1
    (tx_st == T_IDLE));
  c_async_rx: cover property (rx_done && is_async && !rx_full);
  c_overrun: cover property (rx_done && rx_full);
  c_sync_xfer: cover property (sync_trail && tx_cnt == 4'd1);
endmodule
`default_nettype wire

//--- testbench/spx_peer.sv
// remote serial peer: sends and takes asynchronous frames
`timescale 1ns/1ps
`default_nettype none
module spx_peer #(
  parameter int BIT = 16 // clocks per bit at n=0, undivided source
) (
  input  wire logic clk,     // system clock
  input  wire logic tx_line, // line from the channel
  output logic      rx_line  // line to the channel
);
  initial rx_line = 1'b1;
  // one bit held for a whole bit time, changed just after an edge
  task automatic bit_out(input logic b);
    @(posedge clk);
    rx_line <= b;
    repeat (BIT - 1) @(posedge clk);
  endtask
  // start, data lsb first, optional parity, stop level of our choosing
  task automatic send(input logic [8:0] d, input int nb, input logic pen,
                      input logic par, input logic stp);
    bit_out(1'b0);
    for (int i = 0; i < nb; i++) bit_out(d[i]);
    if (pen) bit_out(par);
    bit_out(stp);
    @(posedge clk);
    rx_line <= 1'b1;
  endtask
  // waits for a start bit, then samples each bit at its middle
  task automatic take(output logic [7:0] d, output logic stp);
    int k;
    k = 0;
    while (tx_line !== 1'b0 && k < 400) begin
      @(posedge clk);
      k++;
    end
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      d[i] = tx_line;
    end
    repeat (BIT) @(posedge clk);
    stp = tx_line;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_spx_serial_port.sv
// self-checking bench of the serial channel in asynchronous and synchronous modes
`timescale 1ns/1ps
`default_nettype none
module tb_spx_serial_port;
  import spx_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, slv, rx_line, tx_pin, tx_oe, stp;
  logic        tx_irq, rx_irq;
  logic        loop = 1'b0;
  logic        alt_oe, ck_oe;
  logic [7:0]  got;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n_tx = 0;
  int          n_rx = 0;
  // a released output reads high, as a pulled-up line would
  wire logic   tx_line = tx_oe ? tx_pin : 1'b1;
  always #12.5 clk = ~clk;
  spx_serial_port DUT (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(loop ? tx_line : rx_line), .serial_out_pin(tx_pin),
    .serial_out_oe(tx_oe), .serial_clock_pin_in(1'b0),
    .serial_clock_pin_out(), .serial_clock_pin_oe(ck_oe),
    .alternate_clock_out_pin(), .alternate_clock_out_oe(alt_oe),
    .sub_oscillator_clock(1'b0), .tx_irq(tx_irq), .rx_irq(rx_irq));
  spx_peer PEER (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));
  task automatic final_report;
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // interrupt pulse counters and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_irq === 1'b1) n_tx <= n_tx + 1;
    if (rx_irq === 1'b1) n_rx <= n_rx + 1;
    if (cyc == 30000) begin
      err_count++;
      final_report;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [7:0] m, input logic [7:0] c2);
    apb(1'b1, OFS_MODE, {24'h0, m});
    apb(1'b1, OFS_CTL2, {24'h0, c2});
    apb(1'b1, OFS_CTL1, 32'h5);
  endtask
  task automatic rd_rx;
    repeat (4) @(posedge clk);
    apb(1'b0, OFS_RXB, 32'h0);
  endtask
  task automatic t_idle;
    apb(1'b0, OFS_CTL1, 32'h0);
    chk("ctl1 reset", 32'h2, rd);
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped", 32'h1, {31'h0, slv});
  endtask
  // transmit one byte; irq timing follows the cause bit
  task automatic t_tx(input logic c, input logic [7:0] d);
    int b;
    cfg(MODE_A8, {7'h0, c});
    b = n_tx;
    chk("tx idle", 32'h1, {31'h0, tx_line});
    fork
      PEER.take(got, stp);
      begin
        apb(1'b1, OFS_TXB, {24'h0, d});
        repeat (4) @(posedge clk);
        chk("tx irq load", {31'h0, !c}, n_tx - b);
      end
    join
    chk("tx data", {24'h0, d}, {24'h0, got});
    chk("tx stop", 32'h1, {31'h0, stp});
    repeat (20) @(posedge clk);
    chk("tx irq total", 32'h1, n_tx - b);
  endtask
  task automatic t_len;
    cfg(MODE_A7, 8'h00);
    PEER.send(9'h035, 7, 1'b0, 1'b0, 1'b1);
    rd_rx;
    chk("rx 7 bit", 32'h35, rd);
    cfg(MODE_A9, 8'h00);
    PEER.send(9'h1a5, 9, 1'b0, 1'b0, 1'b1);
    rd_rx;
    chk("rx 9 bit", 32'h1a5, rd);
  endtask
  // second character lands before the first is read
  task automatic t_ovr;
    int b;
    cfg(MODE_A8, 8'h00);
    b = n_rx;
    PEER.send(9'h011, 8, 1'b0, 1'b0, 1'b1);
    PEER.send(9'h022, 8, 1'b0, 1'b0, 1'b1);
    rd_rx;
    chk("rx overrun", 32'h9022, rd);
    chk("rx irq once", 32'h1, n_rx - b);
  endtask
  task automatic t_sleep;
    cfg(8'h85, 8'h00);
    PEER.send(9'h012, 8, 1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    apb(1'b0, OFS_CTL1, 32'h0);
    chk("sleep drop", 32'h0, rd & 32'h8);
    PEER.send(9'h092, 8, 1'b0, 1'b0, 1'b1);
    rd_rx;
    chk("sleep keep", 32'h92, rd);
  endtask
  // even parity: good, bad parity, then a missing stop bit
  task automatic t_rx_err;
    cfg(8'h45, 8'h00);
    PEER.send(9'h05a, 8, 1'b1, 1'b0, 1'b1);
    rd_rx;
    chk("rx clean", 32'h5a, rd);
    PEER.send(9'h05a, 8, 1'b1, 1'b1, 1'b1);
    rd_rx;
    chk("rx parity", 32'hc05a, rd);
    PEER.send(9'h033, 8, 1'b1, 1'b0, 1'b0);
    rd_rx;
    chk("rx framing", 32'ha033, rd);
  endtask
  // sync loopback, clock on the alternate pin, continuous receive
  task automatic t_sync(input logic [7:0] d);
    int b;
    loop <= 1'b1;
    apb(1'b1, OFS_BRG, 32'h7);
    cfg(MODE_SYNC, 8'h34);
    b = n_rx;
    apb(1'b1, OFS_TXB, {24'h0, d});
    chk("alt clk oe", 32'h1, {31'h0, alt_oe});
    chk("clk pin oe", 32'h0, {31'h0, ck_oe});
    repeat (160) @(posedge clk);
    apb(1'b0, OFS_RXB, 32'h0);
    chk("sync rx", {24'h0, d}, rd);
    repeat (160) @(posedge clk);
    apb(1'b0, OFS_RXB, 32'h0);
    chk("cont rx", {24'h0, d}, rd);
    chk("sync irqs", 32'h2, n_rx - b);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_idle;
    t_tx(1'b0, 8'ha5);
    t_tx(1'b1, 8'h3c);
    t_len;
    t_ovr;
    t_sleep;
    t_rx_err;
    t_sync(8'h4b);
    final_report;
  end
endmodule
`default_nettype wire
